// [rtl/psl_map.vh]
`ifndef PSL_MAP_VH
`define PSL_MAP_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSL_CLK_HZ       25000000
`define PSL_BLINK_MS     40
`define PSL_BLINK_CYC    ((`PSL_CLK_HZ / 1000) * `PSL_BLINK_MS)
`define PSL_HOLD_PERIODS 2'h2

// ----------------------------------------
// Port counts
// ----------------------------------------
`define PSL_NPORTS       8
`define PSL_NCFG         4

// ----------------------------------------
// Link mode codes
// ----------------------------------------
`define PSL_MODE_AUTO    2'h0
`define PSL_MODE_F100    2'h1
`define PSL_MODE_F10     2'h2

// ----------------------------------------
// Switch field positions within a pair
// ----------------------------------------
`define PSL_SW_FULL_BIT  0
`define PSL_SW_10M_BIT   1

`endif

// [rtl/psl_port_status.v]
`timescale 1ns/1ps
`include "psl_map.vh"
module psl_port_status #(
  parameter NPORTS    = `PSL_NPORTS,
  parameter NCFG      = `PSL_NCFG,
  parameter BLINK_CYC = `PSL_BLINK_CYC
) (
  // Clock and reset
  input  wire                mclk,
  input  wire                arst_n,
  // Configuration switches, bit 0 is switch 1, ON = 1
  input  wire [2*NCFG-1:0]   cfg_sw,
  // Per-port levels from the PHYs (same clock)
  input  wire [NPORTS-1:0]   link_up,
  input  wire [NPORTS-1:0]   full_duplex,
  input  wire [NPORTS-1:0]   speed_100,
  // Per-port event pulses (same clock, no synchroniser)
  input  wire [NPORTS-1:0]   frame_evt,
  input  wire [NPORTS-1:0]   coll_evt,
  // Link mode request to the PHYs, two bits per port
  output reg  [2*NPORTS-1:0] link_mode,
  // Indicators, high = lit
  output reg  [NPORTS-1:0]   led_link_act,
  output reg  [NPORTS-1:0]   led_dpx_col,
  output reg  [NPORTS-1:0]   led_speed
);

  // ----------------------------------------
  // Switch synchroniser
  // ----------------------------------------
  // Switches move at any time; two flops keep metastability out of the decode
  reg [2*NCFG-1:0] sw_meta_ff;
  reg [2*NCFG-1:0] sw_sync_ff;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sw_meta_ff <= {2*NCFG{1'h0}};
      sw_sync_ff <= {2*NCFG{1'h0}};
    end else begin
      sw_meta_ff <= cfg_sw;
      sw_sync_ff <= sw_meta_ff;
    end
  end

  // ----------------------------------------
  // Link mode decode
  // ----------------------------------------
  // Full switch OFF makes the speed switch a don't-care; code 3 never appears
  function [1:0] psl_decode;
    input full_on;
    input ten_on;
    begin
      if (!full_on)
        psl_decode = `PSL_MODE_AUTO;
      else if (ten_on)
        psl_decode = `PSL_MODE_F10;
      else
        psl_decode = `PSL_MODE_F100;
    end
  endfunction

  reg [2*NPORTS-1:0] nxt_link_mode;
  integer m;

  always @* begin
    nxt_link_mode = {2*NPORTS{1'h0}};
    for (m = 0; m < NCFG; m = m + 1) begin
      nxt_link_mode[2*m +: 2] = psl_decode(sw_sync_ff[2*m + `PSL_SW_FULL_BIT],
                                           sw_sync_ff[2*m + `PSL_SW_10M_BIT]);
    end

    // Ports past the switch bank always negotiate
    for (m = NCFG; m < NPORTS; m = m + 1) begin
      nxt_link_mode[2*m +: 2] = `PSL_MODE_AUTO;
    end
  end

  // ----------------------------------------
  // Link mode register
  // ----------------------------------------
  // Registered so the PHYs see one clean mode change
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link_mode <= {2*NPORTS{1'h0}};
    end else begin
      link_mode <= nxt_link_mode;
    end
  end

  // ----------------------------------------
  // Blink timebase
  // ----------------------------------------
  // One shared square wave keeps all blinking LEDs in phase
  // 32 bits cover any practical half period at this clock
  localparam CW = 32;
  reg [CW-1:0] tick_cnt_ff;
  reg          phase_ff;

  // One-cycle enable at each half period; >= recovers from any overshoot
  wire half_tick  = (tick_cnt_ff >= BLINK_CYC[CW-1:0] - 32'h1);
  wire period_end = half_tick & phase_ff;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_ff <= {CW{1'h0}};
    end else if (half_tick) begin
      tick_cnt_ff <= {CW{1'h0}};
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h1;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= 1'h0;
    end else if (half_tick) begin
      phase_ff <= ~phase_ff;
    end
  end

  // ----------------------------------------
  // Event stretchers
  // ----------------------------------------
  // A new event reloads the hold, so it wins over a period-end decrement
  function [1:0] psl_hold_next;
    input       evt;
    input       tick;
    input [1:0] hold;
    begin
      if (evt)
        psl_hold_next = `PSL_HOLD_PERIODS;
      else if (tick && hold != 2'h0)
        psl_hold_next = hold - 2'h1;
      else
        psl_hold_next = hold;
    end
  endfunction

  // Hold each event until two period ends pass (one to two blink periods) so one dark phase is always shown
  // Steady traffic keeps reloading, so the lamp blinks for as long as it lasts
  reg [1:0] act_hold_ff [0:NPORTS-1];
  reg [1:0] col_hold_ff [0:NPORTS-1];
  integer   k;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (k = 0; k < NPORTS; k = k + 1) begin
        act_hold_ff[k] <= 2'h0;
        col_hold_ff[k] <= 2'h0;
      end
    end else begin
      for (k = 0; k < NPORTS; k = k + 1) begin
        act_hold_ff[k] <= psl_hold_next(frame_evt[k], period_end, act_hold_ff[k]);
        col_hold_ff[k] <= psl_hold_next(coll_evt[k], period_end, col_hold_ff[k]);
      end
    end
  end

  // ----------------------------------------
  // Indicator decode
  // ----------------------------------------
  // Blink while a hold runs, else show the steady state
  // Shared phase: a blink may open in its dark half
  // Every lamp goes dark while the link is down
  function psl_lamp;
    input       link;
    input [1:0] hold;
    input       phase;
    input       steady;
    begin
      if (!link)
        psl_lamp = 1'h0;
      else if (hold != 2'h0)
        psl_lamp = phase;
      else
        psl_lamp = steady;
    end
  endfunction

  reg [NPORTS-1:0] nxt_led_link_act;
  reg [NPORTS-1:0] nxt_led_dpx_col;
  reg [NPORTS-1:0] nxt_led_speed;
  integer p;

  always @* begin
    nxt_led_link_act = {NPORTS{1'h0}};
    nxt_led_dpx_col  = {NPORTS{1'h0}};
    nxt_led_speed    = {NPORTS{1'h0}};
    for (p = 0; p < NPORTS; p = p + 1) begin
      nxt_led_link_act[p] = psl_lamp(link_up[p], act_hold_ff[p], phase_ff, 1'h1);
      nxt_led_dpx_col[p]  = psl_lamp(link_up[p], col_hold_ff[p], phase_ff, full_duplex[p]);
      nxt_led_speed[p]    = psl_lamp(link_up[p], 2'h0, phase_ff, speed_100[p]);
    end
  end

  // ----------------------------------------
  // Indicator registers
  // ----------------------------------------
  // Registered so the lamps never glitch
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      led_link_act <= {NPORTS{1'h0}};
      led_dpx_col  <= {NPORTS{1'h0}};
      led_speed    <= {NPORTS{1'h0}};
    end else begin
      led_link_act <= nxt_led_link_act;
      led_dpx_col  <= nxt_led_dpx_col;
      led_speed    <= nxt_led_speed;
    end
  end

endmodule // psl_port_status

// [tb/psl_assertions.sv]
`timescale 1ns/1ps
module psl_assertions #(parameter BLINK_CYC = 4) (
  input logic        mclk, arst_n,
  input logic [7:0]  cfg_sw, link_up, full_duplex, speed_100, frame_evt, coll_evt,
  input logic [15:0] link_mode,
  input logic [7:0]  led_link_act, led_dpx_col, led_speed);
  // Quiet run on port 1; a blink may last two periods
  logic [7:0] q_ff;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n) q_ff <= 8'h00;
    else q_ff <= (link_up[0] && !frame_evt[0] && !coll_evt[0]) ? q_ff + 8'h01 : 8'h00;
  function automatic [7:0] mp(input [7:0] s);
    for (int i = 0; i < 4; i++) mp[2*i+:2] = s[2*i] ? (s[2*i+1] ? 2'h2 : 2'h1) : 2'h0;
  endfunction
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_on; q_ff > 4*BLINK_CYC+1 |-> led_link_act[0] && led_dpx_col[0] == $past(full_duplex[0]); endproperty
  a_on: assert property (p_on) else $error("steady led wrong");
  property p_off; 1 |=> ((led_link_act | led_dpx_col | led_speed) & ~$past(link_up)) == 8'h00; endproperty
  a_off: assert property (p_off) else $error("led lit without link");
  property p_act; frame_evt[0] && link_up[0] |=> ##[0:9] !led_link_act[0]; endproperty
  a_act: assert property (p_act) else $error("no activity blink");
  property p_col; coll_evt[3] && link_up[3] && !full_duplex[3] |=> ##[0:9] led_dpx_col[3]; endproperty
  a_col: assert property (p_col) else $error("no collision blink");
  property p_spd; 1 |=> led_speed == $past(speed_100 & link_up); endproperty
  a_spd: assert property (p_spd) else $error("speed led wrong");
  property p_hi; link_mode[15:8] == 8'h00; endproperty
  a_hi: assert property (p_hi) else $error("upper port not auto");
  property p_code; (link_mode & (link_mode >> 1) & 16'h5555) == 16'h0000; endproperty
  a_code: assert property (p_code) else $error("bad mode code");
  property p_map; $stable(cfg_sw) [*3] |=> link_mode[7:0] == mp($past(cfg_sw)); endproperty
  a_map: assert property (p_map) else $error("mode map wrong");
  c_act: cover property (frame_evt[0] && link_up[0]);
  c_col: cover property (coll_evt[3]);
  c_f10: cover property (link_mode[1:0] == 2'h2);
endmodule // psl_assertions
bind psl_port_status psl_assertions #(.BLINK_CYC(BLINK_CYC)) i_chk (.mclk, .arst_n, .cfg_sw, .link_up,
  .full_duplex, .speed_100, .frame_evt, .coll_evt, .link_mode, .led_link_act, .led_dpx_col, .led_speed);

// [tb/psl_phy_model.sv]
`timescale 1ns/1ps
module psl_phy_model (
  input  logic [15:0] link_mode,
  input  logic [7:0]  cable, busy, jam, half,
  output logic [7:0]  link_up, full_duplex, speed_100, frame_evt, coll_evt);
  // Auto settles at 100M; a half-only partner stays half under auto, forced modes report full
  always_comb
    for (int p = 0; p < 8; p++) begin
      speed_100[p] = cable[p] && link_mode[2*p+:2] != 2'h2;
      full_duplex[p] = cable[p] && (link_mode[2*p+:2] != 2'h0 || !half[p]);
    end
  assign link_up = cable;
  assign frame_evt = busy & cable;
  assign coll_evt = jam & cable & ~full_duplex;
endmodule // psl_phy_model

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  logic        mclk = 0, arst_n = 0;
  logic [7:0]  cfg_sw = 0, cable = 0, busy = 0, jam = 0, half = 0;
  logic [7:0]  link_up, full_duplex, speed_100, frame_evt, coll_evt, led_link_act, led_dpx_col, led_speed;
  logic [15:0] link_mode;
  int          err_total = 0, n_checks = 0;
  always #20 mclk = ~mclk;
  psl_phy_model i_phy (.link_mode, .cable, .busy, .jam, .half, .link_up, .full_duplex, .speed_100,
    .frame_evt, .coll_evt);
  psl_port_status #(.BLINK_CYC(4)) i_dut (.mclk, .arst_n, .cfg_sw, .link_up, .full_duplex, .speed_100,
    .frame_evt, .coll_evt, .link_mode, .led_link_act, .led_dpx_col, .led_speed);
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task t_cfg;
    logic [1:0] c, q;
    q = 2'h0;
    for (int s = 0; s < 4; s++) begin
      c = s[0] ? (s[1] ? 2'h2 : 2'h1) : 2'h0;
      cyc(1); cfg_sw <= {4{s[1:0]}};
      cyc(2); #1 chk(link_mode, {8'h00, {4{q}}});
      cyc(2); #1 chk(link_mode, {8'h00, {4{c}}});
      q = c;
    end
    $display("cfg test done");
  endtask
  task t_led;
    cyc(1); cfg_sw <= 8'h07; half <= 8'h88; cable <= 8'hFF;
    cyc(6); #1 chk(link_mode, 16'h0006);
    chk(led_link_act, 8'hFF);
    chk(led_speed, 8'hFE);
    chk(led_dpx_col, 8'h77);
    cyc(1); cable <= 8'h5A;
    cyc(2); #1 chk({led_link_act, led_speed}, 16'h5A5A);
    chk(led_dpx_col, 8'h52);
    $display("led test done");
  endtask
  task t_blink;
    int z, o;
    z = 0;
    o = 0;
    cyc(1); cable <= 8'hFF;
    cyc(20); busy <= 8'h01; jam <= 8'h08;
    cyc(1); busy <= 8'h00; jam <= 8'h00;
    repeat (10) begin
      cyc(1); #1 z += !led_link_act[0]; o += led_dpx_col[3];
    end
    chk(16'(z > 0), 16'h0001);
    chk(16'(o > 0), 16'h0001);
    cyc(20); #1 chk({led_link_act[0], led_dpx_col[3]}, 16'h0002);
    $display("blink test done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    cyc(3); arst_n <= 1;
    t_cfg;
    t_led;
    t_blink;
    results;
  end
  initial begin
    #100000;
    err_total++;
    results;
  end
endmodule // tb
